// ==== rtl/bsfs_flag_sem.sv ====
// bsfs_flag_sem: shared 18-bit flag register used as a semaphore by
// several interface units of a bulk_extended_store controller.
// assumes: each unit holds req_valid and its word until it sees
// resp_valid; data transfer engine watches xfer_hold.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - a request holds an 18-bit flag word in bits 0-17, a function code and a parity bit, and the code picks the operation.
// - every request gets exactly one reply, accept or abort.
// - bad address parity gives abort plus a parity error and leaves the register alone.
// - read or write direction and half-capacity mode do not change flag behaviour.
// - code 4 with no overlap ORs the word into the register and accepts.
// - code 4 with overlap leaves the register and aborts.
// - code 5 sets the word's bits and always accepts.
// - code 6 compares like code 4 but never writes.
// - code 7 clears the word's bits and always accepts.
// - a flag request stalls a running data transfer for a short time.
// - queued flag requests are all served before the transfer resumes.
module bsfs_flag_sem #(
  parameter int N_UNITS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // interface unit requests
  input wire logic [N_UNITS-1:0] req_valid,
  input wire bsfs_pkg::bsfs_req_t req_word [N_UNITS],
  input wire logic [N_UNITS-1:0] req_is_write,
  input wire logic half_capacity,
  // replies
  output logic [N_UNITS-1:0] resp_valid,
  output bsfs_pkg::bsfs_resp_t resp,
  // transfer engine and status
  output logic xfer_hold,
  output logic [17:0] flag_reg
);

  // refuse unit counts the one-hot owner and arbiter cannot serve
  if (N_UNITS < 1 || N_UNITS > 16)
  begin : g_bad_units
    $error("bsfs_flag_sem: bad N_UNITS");
  end

  localparam int CW = $clog2(bsfs_pkg::FLAG_OP_CYC + 1);
  // reply lands this many edges after the taking edge
  localparam int ANSWER_CYC = bsfs_pkg::FLAG_OP_CYC + 1;
  localparam logic [CW-1:0] OP_LAST = CW'(bsfs_pkg::FLAG_OP_CYC - 1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bsfs_pkg::bsfs_state_t st;
    logic [17:0] flags;
    logic [N_UNITS-1:0] owner;
    logic [CW-1:0] cnt;
    bsfs_pkg::bsfs_req_t word;
    bsfs_pkg::bsfs_resp_t resp;
  } bsfs_st_t;

  bsfs_st_t s_q;
  bsfs_st_t s_d;
  logic [N_UNITS-1:0] pick;
  logic [N_UNITS-1:0] avail;
  logic take;

  // bitwise or of the one-hot picked request
  function automatic bsfs_pkg::bsfs_req_t sel_word(
    input logic [N_UNITS-1:0] oh,
    input bsfs_pkg::bsfs_req_t w [N_UNITS]
  );
    bsfs_pkg::bsfs_req_t r;
    r = '0;
    for (int i = 0; i < N_UNITS; i++)
    begin
      if (oh[i]) r = r | w[i];
    end
    return r;
  endfunction : sel_word

  // a good word has odd parity over all 25 bits, parity bit included
  function automatic logic par_ok(input bsfs_pkg::bsfs_req_t w);
    return ^w;
  endfunction : par_ok

  // the unit just served is masked for one idle cycle; taking on the raw
  // requests would start an op with no owner while it still holds req_valid
  assign avail = req_valid & ~s_q.owner;
  // only one request is taken while idle, so ops never overlap
  assign take = (s_q.st == bsfs_pkg::ST_IDLE) && (|avail);

  bsfs_arb #(
    .N(N_UNITS)
  ) u_arb (
    .clk(clk),
    .nrst(nrst),
    .req(avail),
    .take(take),
    .pick(pick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic hit;
    s_d = s_q;
    // direction and half_capacity deliberately unused
    hit = |(s_q.word.flag & s_q.flags);
    case (s_q.st)
      bsfs_pkg::ST_IDLE:
      begin
        s_d.owner = '0;
        if (take)
        begin
          s_d.owner = pick;
          s_d.word = sel_word(pick, req_word);
          s_d.cnt = '0;
          s_d.st = bsfs_pkg::ST_BUSY;
        end
      end
      bsfs_pkg::ST_BUSY:
      begin
        s_d.cnt = s_q.cnt + CW'(1);
        if (s_q.cnt == OP_LAST)
        begin
          s_d.st = bsfs_pkg::ST_RESP;
          s_d.resp = '0;
          if (!par_ok(s_q.word))
          begin
            s_d.resp.abort = 1'b1;
            s_d.resp.par_err = 1'b1;
          end
          else
          begin
            case (s_q.word.func)
              bsfs_pkg::FN_TEST_SET:
              begin
                s_d.resp.accept = !hit;
                s_d.resp.abort = hit;
                if (!hit) s_d.flags = s_q.flags | s_q.word.flag;
              end
              bsfs_pkg::FN_SEL_SET:
              begin
                s_d.resp.accept = 1'b1;
                s_d.flags = s_q.flags | s_q.word.flag;
              end
              bsfs_pkg::FN_TEST_ONLY:
              begin
                s_d.resp.accept = !hit;
                s_d.resp.abort = hit;
              end
              bsfs_pkg::FN_SEL_CLR:
              begin
                s_d.resp.accept = 1'b1;
                s_d.flags = s_q.flags & ~s_q.word.flag;
              end
              default:
              begin
                // undefined codes are refused, register kept
                s_d.resp.abort = 1'b1;
              end
            endcase
          end
        end
      end
      bsfs_pkg::ST_RESP:
      begin
        s_d.st = bsfs_pkg::ST_IDLE;
      end
      default:
      begin
        s_d.st = bsfs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q.st <= bsfs_pkg::ST_IDLE;
      s_q.flags <= bsfs_pkg::FLAG_RST;
      s_q.owner <= '0;
      s_q.cnt <= '0;
      s_q.word <= '0;
      s_q.resp <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign resp_valid = (s_q.st == bsfs_pkg::ST_RESP) ? s_q.owner : '0;
  assign resp = s_q.resp;
  assign flag_reg = s_q.flags;
  // hold the transfer while any flag request waits or runs
  assign xfer_hold = (|req_valid) || (s_q.st != bsfs_pkg::ST_IDLE);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_taken;
    take;
  endsequence

  sequence s_answered;
    ##ANSWER_CYC (s_q.st == bsfs_pkg::ST_RESP);
  endsequence

  a_one_reply: assert property (@(posedge clk) disable iff (!nrst)
    s_taken |-> s_answered ##0 ($onehot(resp_valid)
      && (resp.accept ^ resp.abort)))
    else $error("reply missing or not exactly one of accept/abort");

  a_parity_keep: assert property (@(posedge clk) disable iff (!nrst)
    (resp_valid != '0 && resp.par_err) |-> resp.abort && !resp.accept
      && flag_reg == $past(flag_reg, 1))
    else $error("parity abort changed register or accepted");

  a_test_set_ok: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY && s_q.cnt == OP_LAST && par_ok(s_q.word)
      && s_q.word.func == bsfs_pkg::FN_TEST_SET
      && (s_q.word.flag & s_q.flags) == '0)
    |=> resp.accept && flag_reg == ($past(flag_reg) | $past(s_q.word.flag)))
    else $error("test-and-set did not set on free bits");

  a_test_set_busy: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY && s_q.cnt == OP_LAST && par_ok(s_q.word)
      && s_q.word.func == bsfs_pkg::FN_TEST_SET
      && (s_q.word.flag & s_q.flags) != '0)
    |=> resp.abort && $stable(flag_reg))
    else $error("test-and-set on busy bits not refused");

  a_sel_set: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY && s_q.cnt == OP_LAST && par_ok(s_q.word)
      && s_q.word.func == bsfs_pkg::FN_SEL_SET)
    |=> resp.accept && ((flag_reg & $past(s_q.word.flag))
      == $past(s_q.word.flag)))
    else $error("selective set failed");

  a_test_only: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY && s_q.word.func == bsfs_pkg::FN_TEST_ONLY)
    |=> $stable(flag_reg))
    else $error("status test wrote the register");

  a_sel_clr: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY && s_q.cnt == OP_LAST && par_ok(s_q.word)
      && s_q.word.func == bsfs_pkg::FN_SEL_CLR)
    |=> resp.accept && ((flag_reg & $past(s_q.word.flag)) == '0))
    else $error("selective clear failed");

  a_hold_busy: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st != bsfs_pkg::ST_IDLE || req_valid != '0) |-> xfer_hold)
    else $error("transfer not held during flag work");

  a_queue_served: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_RESP && avail != '0)
    |=> xfer_hold ##1 (s_q.st == bsfs_pkg::ST_BUSY && xfer_hold))
    else $error("queued flag request not served next");

  a_serial_ops: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == bsfs_pkg::ST_BUSY) |-> !take && $onehot(s_q.owner))
    else $error("flag operations overlapped");

endmodule : bsfs_flag_sem

`default_nettype wire

// ==== include/bsfs_pkg.sv ====
// bsfs_pkg: types and constants for the bulk store flag semaphore.
// assumes: included before any rtl file that uses bsfs_pkg.
package bsfs_pkg;

  // ----------------------------------------
  // request word layout
  // ----------------------------------------
  localparam int FLAG_W = 18;
  localparam int FLAG_LSB = 0;
  localparam int FUNC_LSB = 21;
  localparam int FUNC_W = 3;
  localparam int PAR_BIT = 24;
  localparam int REQ_W = 25;

  // ----------------------------------------
  // function codes
  // ----------------------------------------
  localparam logic [2:0] FN_TEST_SET = 3'h4;
  localparam logic [2:0] FN_SEL_SET = 3'h5;
  localparam logic [2:0] FN_TEST_ONLY = 3'h6;
  localparam logic [2:0] FN_SEL_CLR = 3'h7;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [17:0] FLAG_RST = 18'h0_0000;
  localparam int CLK_PERIOD_NS = 100;
  // best-case flag service time, ns
  localparam int FLAG_OP_NS = 300;
  // cycles per flag operation, rounded down, at least one
  localparam int FLAG_OP_CYC =
    (FLAG_OP_NS / CLK_PERIOD_NS) < 1 ? 1 : (FLAG_OP_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic par;
    logic [2:0] func;
    logic [2:0] unused;
    logic [17:0] flag;
  } bsfs_req_t;

  typedef struct packed {
    logic accept;
    logic abort;
    logic par_err;
  } bsfs_resp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_RESP = 3'b100
  } bsfs_state_t;

endpackage : bsfs_pkg

// ==== rtl/bsfs_arb.sv ====
// bsfs_arb: rotating-priority round robin pick among requesting units.
// assumes: req held until granted; pick used only when take is high.
`timescale 1ns/1ps
`default_nettype none

module bsfs_arb #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // requests
  input wire logic [N-1:0] req,
  input wire logic take,
  // grant
  output logic [N-1:0] pick
);

  if (N < 1 || N > 16)
  begin : g_bad_n
    $error("bsfs_arb: N out of range");
  end

  typedef struct packed {
    logic [N-1:0] last;
  } bsfs_arb_st_t;

  bsfs_arb_st_t s_q;
  bsfs_arb_st_t s_d;

  // rotate priority past the last winner so no unit starves
  always_comb
  begin
    logic found;
    int idx;
    found = 1'b0;
    idx = 0;
    pick = '0;
    s_d = s_q;
    for (int k = 1; k <= N; k++)
    begin
      idx = 0;
      for (int j = 0; j < N; j++)
      begin
        if (s_q.last[j]) idx = j;
      end
      idx = (idx + k) % N;
      if (!found && req[idx])
      begin
        found = 1'b1;
        pick[idx] = 1'b1;
      end
    end
    if (take && found) s_d.last = pick;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) s_q <= '{last: {1'b1, {(N-1){1'b0}}}};
    else s_q <= s_d;
  end

endmodule : bsfs_arb

`default_nettype wire

// ==== verif/bsfs_unit_model.sv ====
// bsfs_unit_model: interface units posting flag requests.
// assumes: go pulses for one cycle; replies come on resp_valid.
`timescale 1ns/1ps
`default_nettype none

module bsfs_unit_model #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench side
  input wire logic [N-1:0] go,
  input wire bsfs_pkg::bsfs_req_t word [N],
  // design side
  input wire logic [N-1:0] resp_valid,
  input wire bsfs_pkg::bsfs_resp_t resp,
  output logic [N-1:0] req_valid,
  output bsfs_pkg::bsfs_req_t req_word [N],
  // processor side
  output logic [N-1:0] half_exit
);
  // a released word is inverted so a stale value never looks live
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_valid <= '0;
      half_exit <= '0;
      for (int i = 0; i < N; i++)
        req_word[i] <= '1;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (req_valid[i] && resp_valid[i])
        begin
          req_valid[i] <= 1'b0;
          req_word[i] <= ~req_word[i];
          // a parity abort sends the processor to the lower-half exit
          half_exit[i] <= resp.abort && resp.par_err;
        end
        else if (go[i] && !req_valid[i])
        begin
          req_valid[i] <= 1'b1;
          req_word[i] <= word[i];
          half_exit[i] <= 1'b0;
        end
      end
    end
  end
endmodule : bsfs_unit_model
`default_nettype wire

// ==== verif/bsfs_flag_sem_test.sv ====
// bsfs_flag_sem_test: self-checking bench for bsfs_flag_sem.
// assumes: bsfs_pkg compiled first; unit model sits in front.
`timescale 1ns/1ps
`default_nettype none

module bsfs_flag_sem_test;
  localparam int N = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [N-1:0] go = '0;
  logic [N-1:0] wr = '0;
  logic half = 1'b0;
  bsfs_pkg::bsfs_req_t word [N];
  logic [N-1:0] req_valid;
  bsfs_pkg::bsfs_req_t req_word [N];
  logic [N-1:0] resp_valid;
  bsfs_pkg::bsfs_resp_t resp;
  logic xfer_hold;
  logic [17:0] flag_reg;
  logic [N-1:0] half_exit;
  logic [17:0] model_q = 18'h0_0000;
  int mismatches = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  bsfs_unit_model #(.N(N)) bsfs_unit_model_inst (.clk(clk), .nrst(nrst),
    .go(go), .word(word), .resp_valid(resp_valid), .resp(resp),
    .req_valid(req_valid), .req_word(req_word), .half_exit(half_exit));

  bsfs_flag_sem #(.N_UNITS(N)) bsfs_flag_sem_inst (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_word(req_word), .req_is_write(wr),
    .half_capacity(half), .resp_valid(resp_valid), .resp(resp),
    .xfer_hold(xfer_hold), .flag_reg(flag_reg));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [17:0] seen,
    input logic [17:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // one request from unit u; expectation from the bench's own copy
  task automatic op(input int u, input logic [2:0] fn,
    input logic [17:0] f, input logic bad);
    bsfs_pkg::bsfs_req_t w;
    logic ok;
    int n;
    w = '{par: 1'b0, func: fn, unused: 3'h0, flag: f};
    w.par = ~^w ^ bad;
    ok = !bad && (fn == bsfs_pkg::FN_SEL_SET || fn == bsfs_pkg::FN_SEL_CLR
      || ((fn == bsfs_pkg::FN_TEST_SET || fn == bsfs_pkg::FN_TEST_ONLY)
      && (f & model_q) == 18'h0_0000));
    @(posedge clk);
    word[u] <= w;
    go[u] <= 1'b1;
    @(posedge clk);
    go[u] <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      check("xfer_hold", 18'(xfer_hold), 18'h0_0001);
      n++;
    end
    while (resp_valid[u] !== 1'b1 && n < 20);
    // a lost reply is counted once; the run still goes on to the report
    if (resp_valid[u] !== 1'b1)
    begin
      mismatches++;
      return;
    end
    check("reply cycle", 18'(n), 18'(bsfs_pkg::FLAG_OP_CYC + 2));
    if (ok && (fn == bsfs_pkg::FN_TEST_SET || fn == bsfs_pkg::FN_SEL_SET))
      model_q = model_q | f;
    if (ok && fn == bsfs_pkg::FN_SEL_CLR)
      model_q = model_q & ~f;
    check("resp_valid", 18'(resp_valid), 18'(1 << u));
    check("accept", 18'(resp.accept), 18'(ok));
    check("abort", 18'(resp.abort), 18'(!ok));
    check("par_err", 18'(resp.par_err), 18'(bad));
    check("flag_reg", flag_reg, model_q);
    @(negedge clk);
    check("single reply", 18'(resp_valid), 18'h0_0000);
    check("hold released", 18'(xfer_hold), 18'h0_0000);
    check("half exit", 18'(half_exit[u]), 18'(bad));
  endtask : op

  // all units race for one bit: only one may win
  task automatic race();
    bsfs_pkg::bsfs_req_t w;
    int acc;
    int got;
    int n;
    w = '{par: 1'b0, func: 3'h4, unused: 3'h0, flag: 18'h2_0000};
    w.par = ~^w;
    acc = 0;
    got = 0;
    n = 0;
    @(posedge clk);
    for (int i = 0; i < N; i++)
      word[i] <= w;
    go <= '1;
    @(posedge clk);
    go <= '0;
    while (got < N && n < 80)
    begin
      @(negedge clk);
      n++;
      check("hold while queued", 18'(xfer_hold), 18'h0_0001);
      if (resp_valid !== '0)
      begin
        check("one at a time", 18'($countones(resp_valid)),
          18'h0_0001);
        got++;
        acc += int'(resp.accept);
      end
    end
    model_q = model_q | 18'h2_0000;
    check("winners", 18'(acc), 18'h0_0001);
    check("served", 18'(got), 18'(N));
    check("flag_reg", flag_reg, model_q);
  endtask : race

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < N; i++)
      word[i] <= '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("reset flag_reg", flag_reg, 18'h0_0000);
    check("reset resp_valid", 18'(resp_valid), 18'h0_0000);
    op(0, 3'h5, 18'h0_0002, 1'b0);
    op(1, 3'h4, 18'h0_0005, 1'b0);
    op(2, 3'h4, 18'h0_0007, 1'b0);
    op(3, 3'h6, 18'h0_0008, 1'b0);
    op(0, 3'h6, 18'h0_0001, 1'b0);
    op(1, 3'h7, 18'h0_0005, 1'b0);
    op(2, 3'h5, 18'h3_ffff, 1'b1);
    // undefined codes must leave the register alone
    for (int c = 0; c < 4; c++)
      op(3, 3'(c), 18'h0_0004, 1'b0);
    @(posedge clk);
    wr <= '1;
    half <= 1'b1;
    op(0, 3'h4, 18'h0_0010, 1'b0);
    op(0, 3'h7, 18'h0_0010, 1'b0);
    race();
    conclude();
  end
endmodule : bsfs_flag_sem_test
`default_nettype wire
